// *** haptic_input_interpretation_params.svh ***
`ifndef HAPTIC_INPUT_INTERPRETATION_PARAMS_SVH
`define HAPTIC_INPUT_INTERPRETATION_PARAMS_SVH

// Register byte addresses
`define CFG_ADDR 8'h1C
`define LOOP_CTRL_ADDR 8'h20
`define STATUS_ADDR 8'h24

// Configuration register fields
`define CFG_RESET 8'hF5
`define CFG_DIR_BIT 7
`define CFG_STAB_BIT 6
`define CFG_SAMPLE_HI 5
`define CFG_SAMPLE_LO 4
`define CFG_BLANK_HI 3
`define CFG_BLANK_LO 2
`define CFG_DECAY_HI 1
`define CFG_DECAY_LO 0

// Loop control register fields
`define LOOP_CTRL_RESET 8'h00
`define LOOP_CLOSED_BIT 0

// Status register fields
`define STAT_DRIVE_HI 8
`define STAT_DRIVE_LO 0
`define STAT_BRAKE_BIT 9
`define STAT_GAIN_BIT 10
`define STAT_TICK_BIT 11

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing
`define CLK_PERIOD_NS 40
`define SAMPLE_US_0 150
`define SAMPLE_US_1 200
`define SAMPLE_US_2 250
`define SAMPLE_US_3 300
`define US_TO_CYCLES(us) (((us) * 1000) / `CLK_PERIOD_NS)

`endif

// *** haptic_input_interpretation_pkg.sv ***
package haptic_input_interpretation_pkg;

  typedef enum logic [1:0] {
    MAP_UNIDIR,
    MAP_BIDIR_OPEN,
    MAP_BIDIR_CLOSED
  } map_mode_t;

  typedef logic [12:0] period_t;

endpackage : haptic_input_interpretation_pkg

// *** input_drive_mapper.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "haptic_input_interpretation_params.svh"

module input_drive_mapper
  import haptic_input_interpretation_pkg::*;
#(
  parameter int LEVEL_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire map_mode_t mode,
  // Playback level and feedback
  input wire logic [LEVEL_W-1:0] input_level,
  input wire logic brake_request,
  // Signed drive
  output logic signed [LEVEL_W:0] drive_level,
  output logic brake_active
);

  generate
    if (LEVEL_W < 2) begin : g_bad_width
      $error("input_drive_mapper needs LEVEL_W of at least 2");
    end
  endgenerate

  localparam logic [LEVEL_W-1:0] MID = {1'b1, {(LEVEL_W-1){1'b0}}};
  localparam logic signed [LEVEL_W:0] NEG_FULL = -$signed({1'b0, {LEVEL_W{1'b1}}});

  logic signed [LEVEL_W:0] next_drive;
  logic next_brake;
  logic [LEVEL_W-1:0] above_mid;

  always_comb begin
    above_mid = input_level - MID;
    next_drive = '0;
    next_brake = 1'b0;
    unique case (mode)
      MAP_UNIDIR: begin
        // Whole input range is magnitude, so one more bit than bidirectional
        next_drive = $signed({1'b0, input_level});
        next_brake = brake_request;
      end
      MAP_BIDIR_OPEN: begin
        // 2*level - full: 0 -> -full, mid -> +1, full -> +full
        next_drive = $signed({input_level, 1'b0}) - $signed({1'b0, {LEVEL_W{1'b1}}});
        next_brake = (input_level < MID);
      end
      MAP_BIDIR_CLOSED: begin
        if (input_level > MID) begin
          // Upper half stretched back to full scale
          next_drive = $signed({1'b0, above_mid[LEVEL_W-2:0], 1'b0})
                       + $signed({{(LEVEL_W-1){1'b0}}, above_mid[LEVEL_W-2]});
        end
        next_brake = brake_request;
      end
      default: begin
        next_drive = '0;
        next_brake = 1'b0;
      end
    endcase
    // Feedback-decided braking overrides the level with full reverse drive
    if (next_brake && mode != MAP_BIDIR_OPEN) begin
      next_drive = NEG_FULL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_level <= '0;
      brake_active <= 1'b0;
    end else begin
      drive_level <= next_drive;
      brake_active <= next_brake;
    end
  end

endmodule : input_drive_mapper

`default_nettype wire

// *** feedback_timing_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "haptic_input_interpretation_params.svh"

module feedback_timing_gen
  import haptic_input_interpretation_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int BLANK_CYC_0 = 1,
  parameter int BLANK_CYC_1 = 2,
  parameter int BLANK_CYC_2 = 3,
  parameter int BLANK_CYC_3 = 4,
  parameter int DECAY_CYC_0 = 1,
  parameter int DECAY_CYC_1 = 2,
  parameter int DECAY_CYC_2 = 3,
  parameter int DECAY_CYC_3 = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Codes
  input wire logic [1:0] sample_code,
  input wire logic [1:0] blanking_code,
  input wire logic [1:0] decay_code,
  input wire logic gain_reduce_en,
  // Feedback state
  input wire logic brake_active,
  input wire logic brake_near_done,
  // Timing outputs
  output logic sample_tick,
  output logic gain_reduce,
  output logic [CNT_W-1:0] blank_cycles,
  output logic [CNT_W-1:0] decay_cycles
);

  generate
    if (CNT_W < 1 || CNT_W > 31) begin : g_bad_cnt
      $error("feedback_timing_gen CNT_W out of range");
    end
  endgenerate

  function automatic period_t sample_period(input logic [1:0] code);
    unique case (code)
      2'h0: sample_period = period_t'(`US_TO_CYCLES(`SAMPLE_US_0));
      2'h1: sample_period = period_t'(`US_TO_CYCLES(`SAMPLE_US_1));
      2'h2: sample_period = period_t'(`US_TO_CYCLES(`SAMPLE_US_2));
      2'h3: sample_period = period_t'(`US_TO_CYCLES(`SAMPLE_US_3));
    endcase
  endfunction : sample_period

  function automatic logic [CNT_W-1:0] pick(input logic [1:0] code, input int c0,
                                            input int c1, input int c2, input int c3);
    unique case (code)
      2'h0: pick = CNT_W'(c0);
      2'h1: pick = CNT_W'(c1);
      2'h2: pick = CNT_W'(c2);
      2'h3: pick = CNT_W'(c3);
    endcase
  endfunction : pick

  period_t count;

  // A code change takes effect at the next period boundary, never mid-sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      sample_tick <= 1'b0;
    end else if (count == '0) begin
      count <= sample_period(sample_code) - 13'h0001;
      sample_tick <= 1'b1;
    end else begin
      count <= count - 13'h0001;
      sample_tick <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_reduce <= 1'b0;
    end else begin
      gain_reduce <= gain_reduce_en && brake_active && brake_near_done;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_cycles <= '0;
      decay_cycles <= '0;
    end else begin
      blank_cycles <= pick(blanking_code, BLANK_CYC_0, BLANK_CYC_1,
                           BLANK_CYC_2, BLANK_CYC_3);
      decay_cycles <= pick(decay_code, DECAY_CYC_0, DECAY_CYC_1,
                           DECAY_CYC_2, DECAY_CYC_3);
    end
  end

endmodule : feedback_timing_gen

`default_nettype wire

// *** haptic_input_interpretation_ctrl.sv ***
// Operation
// - With direction select 0 the level maps proportionally from zero to full scale using the whole range.
// - In unidirectional mode braking comes only from the feedback brake request.
// - Direction select resets to 1, meaning bidirectional interpretation.
// - Bidirectional open loop maps linearly around mid scale from negative to positive full scale.
// - Bidirectional open loop brakes only while the level is below mid scale.
// - Bidirectional closed loop gives no drive up to mid scale and rises to full scale at the top.
// - Bidirectional closed loop brakes only on the feedback request, whatever the level.
// - With the stabilizer bit set, loop gain is reduced as braking nears its end.
// - Sample code 0..3 selects a resonance sampling period of 150, 200, 250 or 300 us.
// - Bits 3-2 hold the blanking code that sets the wait before each back-EMF conversion.
// - Bits 1-0 hold the current decay code that sets the dissipation wait between drive cycles.
// - The configuration register sits at address 0x1C.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "haptic_input_interpretation_params.svh"

module haptic_input_interpretation_ctrl
  import haptic_input_interpretation_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Playback engine and feedback loop
  input wire logic [7:0] input_level,
  input wire logic brake_request,
  input wire logic brake_near_done,
  // Output stage and feedback timing
  output logic signed [8:0] drive_level,
  output logic brake_active,
  output logic gain_reduce,
  output logic sample_tick,
  output logic [1:0] blanking_code,
  output logic [1:0] current_decay_period,
  output logic [CNT_W-1:0] blank_cycles,
  output logic [CNT_W-1:0] decay_cycles
);

  generate
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("haptic_input_interpretation_ctrl ADDR_W must be 8 to 32");
    end
  endgenerate

  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] reg_addr);
    hits = (addr[ADDR_W-1:2] == {{(ADDR_W-8){1'b0}}, reg_addr[7:2]});
  endfunction : hits

  // Register state
  logic [7:0] input_interp_feedback_timing;
  logic [7:0] loop_ctrl;

  logic input_direction_select;
  logic brake_gain_reduce_en;
  logic [1:0] sample_code;
  logic closed_loop;
  map_mode_t mode;

  assign input_direction_select = input_interp_feedback_timing[`CFG_DIR_BIT];
  assign brake_gain_reduce_en = input_interp_feedback_timing[`CFG_STAB_BIT];
  assign sample_code = input_interp_feedback_timing[`CFG_SAMPLE_HI:`CFG_SAMPLE_LO];
  assign closed_loop = loop_ctrl[`LOOP_CLOSED_BIT];

  // Unidirectional mode follows feedback braking even if the loop is left open
  always_comb begin
    if (!input_direction_select) begin
      mode = MAP_UNIDIR;
    end else if (closed_loop) begin
      mode = MAP_BIDIR_CLOSED;
    end else begin
      mode = MAP_BIDIR_OPEN;
    end
  end

  // Write channel state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic write_hit;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign write_hit = hits(aw_addr, `CFG_ADDR) || hits(aw_addr, `LOOP_CTRL_ADDR)
                     || hits(aw_addr, `STATUS_ADDR);

  always_comb begin
    next_aw_held = aw_held;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
    end else if (do_write) begin
      next_aw_held = 1'b0;
    end
    next_w_held = w_held;
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
    end else if (do_write) begin
      next_w_held = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr <= '0;
    end else begin
      aw_held <= next_aw_held;
      s_axi_awready <= !next_aw_held;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      w_held <= next_w_held;
      s_axi_wready <= !next_w_held;
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Status is read-only; a write there is accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_interp_feedback_timing <= `CFG_RESET;
    end else if (do_write && w_strb[0] && hits(aw_addr, `CFG_ADDR)) begin
      input_interp_feedback_timing <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_ctrl <= `LOOP_CTRL_RESET;
    end else if (do_write && w_strb[0] && hits(aw_addr, `LOOP_CTRL_ADDR)) begin
      loop_ctrl <= {7'h00, w_data[`LOOP_CLOSED_BIT]};
    end
  end

  // Codes leave the block exactly as stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blanking_code <= 2'((`CFG_RESET >> `CFG_BLANK_LO) & 8'h03);
      current_decay_period <= 2'((`CFG_RESET >> `CFG_DECAY_LO) & 8'h03);
    end else begin
      blanking_code <= input_interp_feedback_timing[`CFG_BLANK_HI:`CFG_BLANK_LO];
      current_decay_period <= input_interp_feedback_timing[`CFG_DECAY_HI:`CFG_DECAY_LO];
    end
  end

  // Read channel
  logic next_rvalid;
  logic [31:0] read_word;
  logic [1:0] read_resp;
  logic [31:0] status_word;

  assign next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STAT_DRIVE_HI:`STAT_DRIVE_LO] = drive_level;
    status_word[`STAT_BRAKE_BIT] = brake_active;
    status_word[`STAT_GAIN_BIT] = gain_reduce;
    status_word[`STAT_TICK_BIT] = sample_tick;
  end

  always_comb begin
    read_word = 32'h0000_0000;
    read_resp = `RESP_OKAY;
    if (hits(s_axi_araddr, `CFG_ADDR)) begin
      read_word = {24'h000000, input_interp_feedback_timing};
    end else if (hits(s_axi_araddr, `LOOP_CTRL_ADDR)) begin
      read_word = {24'h000000, loop_ctrl};
    end else if (hits(s_axi_araddr, `STATUS_ADDR)) begin
      read_word = status_word;
    end else begin
      read_resp = `RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_resp;
      end
    end
  end

  input_drive_mapper #(
    .LEVEL_W(8)
  ) u_mapper (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode),
    .input_level(input_level),
    .brake_request(brake_request),
    .drive_level(drive_level),
    .brake_active(brake_active)
  );

  feedback_timing_gen #(
    .CNT_W(CNT_W)
  ) u_timing (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_code(sample_code),
    .blanking_code(input_interp_feedback_timing[`CFG_BLANK_HI:`CFG_BLANK_LO]),
    .decay_code(input_interp_feedback_timing[`CFG_DECAY_HI:`CFG_DECAY_LO]),
    .gain_reduce_en(brake_gain_reduce_en),
    .brake_active(brake_active),
    .brake_near_done(brake_near_done),
    .sample_tick(sample_tick),
    .gain_reduce(gain_reduce),
    .blank_cycles(blank_cycles),
    .decay_cycles(decay_cycles)
  );

endmodule : haptic_input_interpretation_ctrl

`default_nettype wire

// *** haptic_ctrl_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "haptic_input_interpretation_params.svh"

module haptic_ctrl_checker #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Drive and timing
  input wire logic brake_near_done,
  input wire logic signed [8:0] drive_level,
  input wire logic brake_active,
  input wire logic gain_reduce,
  input wire logic sample_tick,
  input wire logic [1:0] blanking_code,
  input wire logic [1:0] current_decay_period,
  input wire logic [CNT_W-1:0] blank_cycles,
  input wire logic [CNT_W-1:0] decay_cycles
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_WRITE_ACK: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_READ_LAT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  AST_RD_UPPER: assert property (
    s_axi_rvalid && s_axi_rresp == `RESP_OKAY |-> s_axi_rdata[31:12] == 20'h00000)
    else $error("read data upper bits set");
  AST_BRAKE_SIGN: assert property (brake_active == drive_level[8])
    else $error("brake flag and drive sign disagree");
  AST_GAIN: assert property (gain_reduce |-> $past(brake_active) && $past(brake_near_done))
    else $error("gain reduced without braking near end");
  AST_FULL_SCALE: assert property (drive_level != 9'h100)
    else $error("drive beyond negative full scale");
  AST_TICK_PULSE: assert property (sample_tick |=> !sample_tick)
    else $error("sample tick longer than one cycle");
  AST_BLANK_TAB: assert property (
    $past(aresetn) && $past(aresetn, 2) && $stable(blanking_code)
    |-> blank_cycles == {{(CNT_W-2){1'b0}}, blanking_code} + 1'b1)
    else $error("blanking count mismatch");
  AST_DECAY_TAB: assert property (
    $past(aresetn) && $past(aresetn, 2) && $stable(current_decay_period)
    |-> decay_cycles == {{(CNT_W-2){1'b0}}, current_decay_period} + 1'b1)
    else $error("decay count mismatch");

  cover property (gain_reduce);
  cover property (sample_tick);
  cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule : haptic_ctrl_checker

`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "haptic_input_interpretation_params.svh"
`define CHECK_EQ(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb;
  import haptic_input_interpretation_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, input_level = 8'h80;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, brake_active, gain_reduce, sample_tick;
  logic brake_request = 0, brake_near_done = 0;
  logic [1:0] bresp, rresp, blanking_code, current_decay_period, r;
  logic signed [8:0] drive_level;
  logic [15:0] blank_cycles, decay_cycles;
  logic [31:0] d;
  int fail_count = 0, samples_checked = 0, n;

  haptic_input_interpretation_ctrl uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .input_level(input_level), .brake_request(brake_request),
    .brake_near_done(brake_near_done), .drive_level(drive_level),
    .brake_active(brake_active), .gain_reduce(gain_reduce), .sample_tick(sample_tick),
    .blanking_code(blanking_code), .current_decay_period(current_decay_period),
    .blank_cycles(blank_cycles), .decay_cycles(decay_cycles));

  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // Address and data are offered together and each is dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                           output logic [1:0] resp);
    logic aw_done, w_done;
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    aw_done = 1'b0; w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata; resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
    axi_write(a, v, 4'hF, r);
    `CHECK_EQ("bresp", `RESP_OKAY, r)
  endtask : wr_ok

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_read(a, d, r);
    `CHECK_EQ("rresp", er, r)
    `CHECK_EQ("rdata", e, d)
  endtask : rd_chk

  // Gain reduction lags the brake flag by one cycle, so three edges are allowed
  task automatic drv_chk(input logic [7:0] lv, input logic req, input logic signed [8:0] e,
                         input logic eb);
    @(posedge aclk);
    input_level <= lv; brake_request <= req;
    repeat (3) @(posedge aclk);
    #1;
    `CHECK_EQ("drive_level", e, drive_level)
    `CHECK_EQ("brake_active", eb, brake_active)
  endtask : drv_chk

  task automatic tick_period(output int cnt);
    do begin @(posedge aclk); #1; end while (sample_tick !== 1'b1);
    cnt = 0;
    do begin @(posedge aclk); #1; cnt++; end while (sample_tick !== 1'b1);
  endtask : tick_period

  initial begin
    #(40 * 60000);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h1C, 32'hF5, `RESP_OKAY);
    `CHECK_EQ("blanking_code", 2'h1, blanking_code)
    `CHECK_EQ("decay_code", 2'h1, current_decay_period)
    rd_chk(8'h20, 32'h0, `RESP_OKAY);
    rd_chk(8'h40, 32'h0, `RESP_SLVERR);
    axi_write(8'h40, 32'hFF, 4'hF, r);
    `CHECK_EQ("bresp unmapped", `RESP_SLVERR, r)
    axi_write(8'h1C, 32'h00, 4'h0, r);
    rd_chk(8'h1C, 32'hF5, `RESP_OKAY);
    wr_ok(8'h24, 32'hFFF);
    tick_period(n);
    `CHECK_EQ("period code 3", 7500, n)
    // Bidirectional open loop: feedback brake request has no say here
    drv_chk(8'h00, 1'b0, -9'sd255, 1'b1);
    drv_chk(8'h40, 1'b0, -9'sd127, 1'b1);
    drv_chk(8'h80, 1'b0, 9'sd1, 1'b0);
    drv_chk(8'hC0, 1'b1, 9'sd129, 1'b0);
    drv_chk(8'hFF, 1'b0, 9'sd255, 1'b0);
    // Bidirectional closed loop
    wr_ok(8'h20, 32'h1);
    drv_chk(8'h00, 1'b0, 9'sd0, 1'b0);
    drv_chk(8'h80, 1'b0, 9'sd0, 1'b0);
    drv_chk(8'hC0, 1'b0, 9'sd129, 1'b0);
    drv_chk(8'hFF, 1'b0, 9'sd255, 1'b0);
    @(posedge aclk);
    brake_near_done <= 1'b1;
    drv_chk(8'hFF, 1'b1, -9'sd255, 1'b1);
    `CHECK_EQ("gain_reduce on", 1'b1, gain_reduce)
    wr_ok(8'h1C, 32'hB5);
    repeat (3) @(posedge aclk);
    #1;
    `CHECK_EQ("gain_reduce off", 1'b0, gain_reduce)
    // Unidirectional only with the loop already closed
    wr_ok(8'h1C, 32'h75);
    drv_chk(8'h00, 1'b0, 9'sd0, 1'b0);
    drv_chk(8'h80, 1'b0, 9'sd128, 1'b0);
    drv_chk(8'hFF, 1'b0, 9'sd255, 1'b0);
    drv_chk(8'h80, 1'b1, -9'sd255, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr_ok(8'h1C, 32'hF0 | (c << 2) | c);
      repeat (3) @(posedge aclk);
      #1;
      `CHECK_EQ("blanking_code", c[1:0], blanking_code)
      `CHECK_EQ("decay_code", c[1:0], current_decay_period)
      `CHECK_EQ("blank_cycles", c[15:0] + 16'h1, blank_cycles)
      `CHECK_EQ("decay_cycles", c[15:0] + 16'h1, decay_cycles)
      rd_chk(8'h1C, 32'hF0 | (c << 2) | c, `RESP_OKAY);
    end
    wr_ok(8'h1C, 32'hC5);
    tick_period(n);
    tick_period(n);
    `CHECK_EQ("period code 0", 3750, n)
    complete_run();
  end
endmodule : tb

bind haptic_input_interpretation_ctrl haptic_ctrl_checker #(.CNT_W(CNT_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .brake_near_done(brake_near_done), .drive_level(drive_level),
  .brake_active(brake_active), .gain_reduce(gain_reduce), .sample_tick(sample_tick),
  .blanking_code(blanking_code), .current_decay_period(current_decay_period),
  .blank_cycles(blank_cycles), .decay_cycles(decay_cycles));

`default_nettype wire
